// [design/mspx_pkg.sv]
// Purpose: shared constants for the move/subtract/flag-move execution block
// Assumes: 17-bit instruction words, 16-bit data, 17th bit is the memory tag
// Notes: opcodes given as bit patterns of the upper instruction field
package mspx_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int INSN_W = 17;
    localparam int DATA_W = 16;
    localparam int ACC_SEL_W = 2;
    localparam int NUM_ACC = 4;
    localparam int ADRS_W = 8;
    // ----------------------------------------
    // opcode patterns, bits 16..10; test flag pattern is bits 16..11
    // ----------------------------------------
    localparam logic [6:0] OP_SUB_PH = 7'h32;
    localparam logic [6:0] OP_SUB_PH_STR = 7'h33;
    localparam logic [5:0] OP_TEST_FLAG = 6'h35;
    localparam logic [6:0] OP_STR_GRP = 7'h73;
    // ----------------------------------------
    // string move sub-codes, bits 7..2
    // ----------------------------------------
    localparam logic [5:0] SUB_FROM_PH = 6'h08;
    localparam logic [5:0] SUB_ACC_ACC = 6'h0e;
    // ----------------------------------------
    // addressing mode codes for indexed base+index and direct
    // ----------------------------------------
    localparam logic [7:0] ADRS_INDEXED = 8'h0f;
    localparam logic [7:0] ADRS_DIRECT = 8'h00;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    typedef enum logic [3:0] {
        MSPX_OP_NONE,
        MSPX_OP_SUB_PH,
        MSPX_OP_SUB_PH_STR,
        MSPX_OP_TEST_FLAG,
        MSPX_OP_STR_FROM_PH,
        MSPX_OP_STR_ACC_ACC,
        MSPX_OP_STR_LOOKUP,
        MSPX_OP_STR_LOAD,
        MSPX_OP_STR_STORE
    } mspx_op_e;
endpackage : mspx_pkg

// [design/mspx_decode.sv]
// Purpose: instruction decoder for the move group
// Assumes: instruction word is stable while insn_valid_in is high
// Notes: combinational, no state
`timescale 1ns/1ps
module mspx_decode (
    input wire logic [16:0] insn_in,        // first instruction word
    output mspx_pkg::mspx_op_e op_out,      // decoded operation
    output logic [1:0] acc_sel_out,         // accumulator select
    output logic alt_out,                   // alternate accumulator flag
    output logic [2:0] flag_sel_out,        // test flag selector
    output logic [7:0] adrs_out             // addressing mode field
);
    always_comb begin
        op_out = mspx_pkg::MSPX_OP_NONE;
        acc_sel_out = insn_in[9:8];
        alt_out = insn_in[1];
        flag_sel_out = insn_in[10:8];
        adrs_out = insn_in[7:0];
        if (insn_in[16:10] == mspx_pkg::OP_SUB_PH) begin
            op_out = mspx_pkg::MSPX_OP_SUB_PH;
        end else if (insn_in[16:10] == mspx_pkg::OP_SUB_PH_STR) begin
            op_out = mspx_pkg::MSPX_OP_SUB_PH_STR;
        end else if (insn_in[16:11] == mspx_pkg::OP_TEST_FLAG) begin
            op_out = mspx_pkg::MSPX_OP_TEST_FLAG;
        end else if (insn_in[16:10] == mspx_pkg::OP_STR_GRP) begin
            case (insn_in[7:2])
                mspx_pkg::SUB_FROM_PH: op_out = mspx_pkg::MSPX_OP_STR_FROM_PH;
                mspx_pkg::SUB_ACC_ACC: op_out = mspx_pkg::MSPX_OP_STR_ACC_ACC;
                default: op_out = mspx_pkg::MSPX_OP_NONE;
            endcase
        end else if (insn_in[16:12] == 5'h0b && insn_in[11:10] == 2'h3) begin
            op_out = mspx_pkg::MSPX_OP_STR_LOOKUP;
        end else if (insn_in[16:13] == 4'h2 && insn_in[11:10] == 2'h3) begin
            op_out = mspx_pkg::MSPX_OP_STR_LOAD;
            alt_out = insn_in[12];
        end else if (insn_in[16:13] == 4'h1 && insn_in[11:10] == 2'h3) begin
            op_out = mspx_pkg::MSPX_OP_STR_STORE;
            alt_out = insn_in[12];
        end
    end
endmodule : mspx_decode

// [design/mspx_exec.sv]
// Purpose: execute move-subtract-product-high, flag move and string moves
// Assumes: memories answer combinationally; one instruction per valid pulse
// Notes: accumulator strings are two words; word 1 is the second word
// Summary of operation
// - single form: acc minus product high, load multiplier
// - move-subtract sets tag, overflow, sign, zero, carry
// - opcode 0110010 decodes single move-subtract
// - bit 10 set selects string variant
// - string form subtracts from second word
// - indexed address is pointer three plus index five
// - test flag copied to memory 17th bit
// - string move from product high writes word two
// - lookup copies program string to data memory
// - pointer-indirect load/store of accumulator string
// - accumulator to alternate copy either direction
// - product-high string move keeps carry and zero
`timescale 1ns/1ps
module mspx_exec (
    input wire logic ref_clk_in,              // core clock 40 MHz
    input wire logic rst_n_in,                // async reset, active low
    input wire logic insn_valid_in,           // instruction strobe
    input wire logic [16:0] insn_in,          // first instruction word
    input wire logic [15:0] ext_word_in,      // second word, address or offset
    input wire logic [15:0] product_high_reg_in,      // product high value
    input wire logic [15:0] pointer_register_three_in, // base pointer
    input wire logic [15:0] index_register_five_in,   // index register
    input wire logic [7:0] test_flags_in,     // status test flags
    input wire logic [16:0] dmem_rdata_in,    // data memory read, bit 16 tag
    input wire logic [16:0] dmem_rdata2_in,   // data memory second word
    input wire logic [15:0] pmem_rdata_in,    // program memory first word
    input wire logic [15:0] pmem_rdata2_in,   // program memory second word
    output logic [15:0] dmem_addr_out,        // data memory byte address
    output logic dmem_we_out,                 // data memory write
    output logic dmem_tag_only_out,           // write only tag bit
    output logic [16:0] dmem_wdata_out,       // data memory write word
    output logic [16:0] dmem_wdata2_out,      // data memory second write word
    output logic [15:0] pmem_addr_out,        // program memory address
    output logic [15:0] multiplier_operand_reg_out, // multiplier operand
    output logic [15:0] acc_w0_out [4],       // accumulator word 0
    output logic [15:0] acc_w1_out [4],       // accumulator word 1
    output logic [15:0] alt_w0_out [4],       // alternate word 0
    output logic [15:0] alt_w1_out [4],       // alternate word 1
    output logic tag_flag_out,                // memory tag status
    output logic overflow_flag_out,           // overflow
    output logic sign_flag_out,               // sign
    output logic zero_flag_out,               // zero
    output logic carry_flag_out               // carry
);
    mspx_pkg::mspx_op_e op;
    logic [1:0] acc_sel;
    logic alt;
    logic [2:0] flag_sel;
    logic [7:0] adrs;
    logic [15:0] acc_w0_r [4];
    logic [15:0] acc_w1_r [4];
    logic [15:0] alt_w0_r [4];
    logic [15:0] alt_w1_r [4];
    logic [15:0] minuend;
    logic [16:0] diff;
    logic [15:0] mem_addr;
    logic is_sub;

    mspx_decode u_dec (
        .insn_in(insn_in),
        .op_out(op),
        .acc_sel_out(acc_sel),
        .alt_out(alt),
        .flag_sel_out(flag_sel),
        .adrs_out(adrs)
    );

    // ----------------------------------------
    // address and subtraction datapath
    // ----------------------------------------
    always_comb begin
        if (adrs == mspx_pkg::ADRS_INDEXED) begin
            mem_addr = pointer_register_three_in + index_register_five_in;
        end else begin
            mem_addr = ext_word_in;
        end
    end

    assign is_sub = insn_valid_in && (op == mspx_pkg::MSPX_OP_SUB_PH || op == mspx_pkg::MSPX_OP_SUB_PH_STR);
    // string form uses second word of the accumulator string
    assign minuend = (op == mspx_pkg::MSPX_OP_SUB_PH_STR) ? acc_w1_r[acc_sel] : acc_w0_r[acc_sel];
    assign diff = {1'b0, minuend} - {1'b0, product_high_reg_in};
    assign dmem_addr_out = mem_addr;
    assign pmem_addr_out = acc_w0_r[acc_sel];

    // ----------------------------------------
    // memory writes
    // ----------------------------------------
    always_comb begin
        dmem_we_out = 1'b0;
        dmem_tag_only_out = 1'b0;
        dmem_wdata_out = 17'h00000;
        dmem_wdata2_out = 17'h00000;
        if (insn_valid_in) begin
            case (op)
                mspx_pkg::MSPX_OP_TEST_FLAG: begin
                    dmem_we_out = 1'b1;
                    dmem_tag_only_out = 1'b1;
                    dmem_wdata_out = {test_flags_in[flag_sel], 16'h0000};
                end
                mspx_pkg::MSPX_OP_STR_LOOKUP: begin
                    dmem_we_out = 1'b1;
                    dmem_wdata_out = {1'b0, pmem_rdata_in};
                    dmem_wdata2_out = {1'b0, pmem_rdata2_in};
                end
                mspx_pkg::MSPX_OP_STR_STORE: begin
                    dmem_we_out = 1'b1;
                    dmem_wdata_out = {1'b0, alt ? alt_w0_r[acc_sel] : acc_w0_r[acc_sel]};
                    dmem_wdata2_out = {1'b0, alt ? alt_w1_r[acc_sel] : acc_w1_r[acc_sel]};
                end
                default: begin
                    dmem_we_out = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // accumulator file
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 4; i++) begin
                acc_w0_r[i] <= mspx_pkg::RST_WORD;
                acc_w1_r[i] <= mspx_pkg::RST_WORD;
                alt_w0_r[i] <= mspx_pkg::RST_WORD;
                alt_w1_r[i] <= mspx_pkg::RST_WORD;
            end
        end else if (insn_valid_in) begin
            case (op)
                mspx_pkg::MSPX_OP_SUB_PH: acc_w0_r[acc_sel] <= diff[15:0];
                mspx_pkg::MSPX_OP_SUB_PH_STR: acc_w1_r[acc_sel] <= diff[15:0];
                mspx_pkg::MSPX_OP_STR_FROM_PH: begin
                    if (alt) alt_w1_r[acc_sel] <= product_high_reg_in;
                    else acc_w1_r[acc_sel] <= product_high_reg_in;
                end
                mspx_pkg::MSPX_OP_STR_ACC_ACC: begin
                    if (insn_in[0]) begin
                        acc_w0_r[acc_sel] <= alt_w0_r[acc_sel];
                        acc_w1_r[acc_sel] <= alt_w1_r[acc_sel];
                    end else begin
                        alt_w0_r[acc_sel] <= acc_w0_r[acc_sel];
                        alt_w1_r[acc_sel] <= acc_w1_r[acc_sel];
                    end
                end
                mspx_pkg::MSPX_OP_STR_LOAD: begin
                    if (alt) begin
                        alt_w0_r[acc_sel] <= dmem_rdata_in[15:0];
                        alt_w1_r[acc_sel] <= dmem_rdata2_in[15:0];
                    end else begin
                        acc_w0_r[acc_sel] <= dmem_rdata_in[15:0];
                        acc_w1_r[acc_sel] <= dmem_rdata2_in[15:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // multiplier operand register
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            multiplier_operand_reg_out <= mspx_pkg::RST_WORD;
        end else if (is_sub) begin
            multiplier_operand_reg_out <= dmem_rdata_in[15:0];
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tag_flag_out <= 1'b0;
            overflow_flag_out <= 1'b0;
            sign_flag_out <= 1'b0;
            zero_flag_out <= 1'b0;
            carry_flag_out <= 1'b0;
        end else if (is_sub) begin
            tag_flag_out <= dmem_rdata_in[16];
            overflow_flag_out <= (minuend[15] != product_high_reg_in[15]) && (diff[15] != minuend[15]);
            sign_flag_out <= diff[15];
            zero_flag_out <= (diff[15:0] == 16'h0000);
            carry_flag_out <= ~diff[16];
        end
        // product-high string move leaves carry and zero untouched
    end

    assign acc_w0_out = acc_w0_r;
    assign acc_w1_out = acc_w1_r;
    assign alt_w0_out = alt_w0_r;
    assign alt_w1_out = alt_w1_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_sub_result: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        insn_valid_in && op == mspx_pkg::MSPX_OP_SUB_PH |=> acc_w0_r[$past(acc_sel)] ==
        $past(acc_w0_r[acc_sel]) - $past(product_high_reg_in))
        else $error("accumulator difference wrong");
    a_mr_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_sub |=> multiplier_operand_reg_out == $past(dmem_rdata_in[15:0]))
        else $error("multiplier operand not loaded");
    a_zero_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_sub |=> zero_flag_out == ($past(diff[15:0]) == 16'h0000))
        else $error("zero flag wrong");
    a_tag_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_sub |=> tag_flag_out == $past(dmem_rdata_in[16]))
        else $error("tag flag wrong");
    a_decode_single: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        insn_in[16:10] == 7'h32 |-> op == mspx_pkg::MSPX_OP_SUB_PH)
        else $error("single form not decoded");
    a_decode_string: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        insn_in[16:10] == 7'h33 |-> op == mspx_pkg::MSPX_OP_SUB_PH_STR)
        else $error("string form not decoded");
    a_str_sub: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        insn_valid_in && op == mspx_pkg::MSPX_OP_SUB_PH_STR |=> acc_w1_r[$past(acc_sel)] ==
        $past(acc_w1_r[acc_sel]) - $past(product_high_reg_in))
        else $error("string difference wrong");
    a_indexed_addr: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        adrs == mspx_pkg::ADRS_INDEXED |-> dmem_addr_out ==
        16'(pointer_register_three_in + index_register_five_in))
        else $error("indexed address wrong");
    a_flag_move: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        insn_valid_in && op == mspx_pkg::MSPX_OP_TEST_FLAG |-> dmem_we_out && dmem_tag_only_out
        && dmem_wdata_out[16] == test_flags_in[flag_sel] ##1 $stable(carry_flag_out)
        && $stable(zero_flag_out) && $stable(sign_flag_out) && $stable(overflow_flag_out)
        && $stable(tag_flag_out))
        else $error("flag move wrong");
    a_ph_keeps_cz: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        insn_valid_in && op == mspx_pkg::MSPX_OP_STR_FROM_PH |=> $stable(carry_flag_out)
        && $stable(zero_flag_out))
        else $error("carry or zero changed");
    a_ph_to_w1: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        insn_valid_in && op == mspx_pkg::MSPX_OP_STR_FROM_PH && !alt |=>
        acc_w1_r[$past(acc_sel)] == $past(product_high_reg_in))
        else $error("product high not in word two");
    c_sub: cover property (@(posedge ref_clk_in) is_sub);
    c_flag: cover property (@(posedge ref_clk_in) insn_valid_in && op == mspx_pkg::MSPX_OP_TEST_FLAG);
    c_lookup: cover property (@(posedge ref_clk_in) insn_valid_in && op == mspx_pkg::MSPX_OP_STR_LOOKUP);
    c_from_ph: cover property (@(posedge ref_clk_in) insn_valid_in && op == mspx_pkg::MSPX_OP_STR_FROM_PH);
endmodule : mspx_exec

// [verification/test_move_sub_product_and_flag_exec.sv]
// Purpose: self-checking bench for the move-subtract, flag move and string move block
// Assumes: one instruction per valid cycle, memories answered by the bench
// Notes: comb write signals checked mid-cycle, registers after the taking edge
`timescale 1ns/1ps
module test_move_sub_product_and_flag_exec;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic valid = 1'b0;
    logic [16:0] insn = 17'h00000;
    logic [15:0] ext = 16'h0000, ph = 16'h0000, r3 = 16'h0000, r5 = 16'h0000, pm1 = 16'h0000, pm2 = 16'h0000;
    logic [7:0] tf = 8'h00;
    logic [16:0] rd1 = 17'h00000, rd2 = 17'h00000;
    logic [15:0] v_ph = 16'h0000, v_r3 = 16'h0000, v_r5 = 16'h0000, v_pm1 = 16'h0000, v_pm2 = 16'h0000;
    logic [7:0] v_tf = 8'h00;
    logic [16:0] v_rd1 = 17'h00000, v_rd2 = 17'h00000;
    logic [15:0] d_addr, p_addr, mr, diff;
    logic d_we, d_tag, f_tag, f_ov, f_sg, f_z, f_c;
    logic [16:0] d_wd, d_wd2;
    logic [15:0] acc0 [4];
    logic [15:0] acc1 [4];
    logic [15:0] alt0 [4];
    logic [15:0] alt1 [4];
    logic [4:0] e_flags;
    logic [15:0] sa [4] = '{16'h1234, 16'h0005, 16'h0001, 16'h8000};
    logic [15:0] sb [4] = '{16'h0034, 16'h0005, 16'h0002, 16'h0001};
    int n_errors = 0;
    int total_checks = 0;

    mspx_exec mspx_exec_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .insn_valid_in(valid), .insn_in(insn),
        .ext_word_in(ext), .product_high_reg_in(ph), .pointer_register_three_in(r3), .index_register_five_in(r5),
        .test_flags_in(tf), .dmem_rdata_in(rd1), .dmem_rdata2_in(rd2), .pmem_rdata_in(pm1), .pmem_rdata2_in(pm2),
        .dmem_addr_out(d_addr), .dmem_we_out(d_we), .dmem_tag_only_out(d_tag), .dmem_wdata_out(d_wd),
        .dmem_wdata2_out(d_wd2), .pmem_addr_out(p_addr), .multiplier_operand_reg_out(mr), .acc_w0_out(acc0),
        .acc_w1_out(acc1), .alt_w0_out(alt0), .alt_w1_out(alt1), .tag_flag_out(f_tag), .overflow_flag_out(f_ov),
        .sign_flag_out(f_sg), .zero_flag_out(f_z), .carry_flag_out(f_c));

    always #12.5 ref_clk_in = ~ref_clk_in;

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic start(input logic [16:0] i, input logic [15:0] e);
        @(posedge ref_clk_in);
        valid <= 1'b1;
        insn <= i;
        ext <= e;
        {ph, r3, r5, tf, rd1, rd2, pm1, pm2} <= {v_ph, v_r3, v_r5, v_tf, v_rd1, v_rd2, v_pm1, v_pm2};
        @(negedge ref_clk_in);
    endtask : start

    task automatic finish();
        @(posedge ref_clk_in);
        valid <= 1'b0;
        @(negedge ref_clk_in);
    endtask : finish

    task automatic load(input logic [1:0] n, input logic alt, input logic [15:0] w0, input logic [15:0] w1);
        v_rd1 = {1'b0, w0};
        v_rd2 = {1'b0, w1};
        start({4'h2, alt, 2'b11, n, mspx_pkg::ADRS_DIRECT}, 16'h0040);
        check(17'(d_addr), 17'h00040, "load address");
        check(17'(d_we), 17'h00000, "load writes no memory");
        finish();
    endtask : load

    task automatic sub_case(input logic [1:0] n, input logic [15:0] a, input logic [15:0] b, input logic str);
        load(n, 1'b0, str ? 16'h5a5a : a, str ? a : 16'h0f0f);
        check(17'(str ? acc1[n] : acc0[n]), 17'(a), "load word");
        v_r3 = 16'h0100 + 16'(n);
        v_r5 = 16'h0022;
        v_ph = b;
        v_rd1 = {a[0], a ^ 16'hc3c0};
        start({str ? mspx_pkg::OP_SUB_PH_STR : mspx_pkg::OP_SUB_PH, n, mspx_pkg::ADRS_INDEXED}, 16'h7777);
        check(17'(d_addr), 17'(v_r3 + v_r5), "indexed address");
        finish();
        diff = a - b;
        e_flags = {a[0], (a[15] != b[15]) && (diff[15] != a[15]), diff[15], diff == 16'h0000, a >= b};
        check(17'(str ? acc1[n] : acc0[n]), 17'(diff), "difference");
        check(17'(str ? acc0[n] : acc1[n]), 17'(str ? 16'h5a5a : 16'h0f0f), "other word");
        check(17'(mr), 17'(a ^ 16'hc3c0), "multiplier load");
        check(17'({f_tag, f_ov, f_sg, f_z, f_c}), 17'(e_flags), "subtract flags");
    endtask : sub_case

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(negedge ref_clk_in);
        check(17'(acc0[0]), 17'h00000, "reset accumulator");
        check(17'({f_tag, f_ov, f_sg, f_z, f_c}), 17'h00000, "reset flags");
        check(17'(mr), 17'h00000, "reset multiplier");
        for (int k = 0; k < 8; k++) begin
            sub_case(2'(k), sa[k % 4], sb[k % 4], k >= 4);
        end
        $display("test move_subtract done");
        v_tf = 8'h5c;
        for (int s = 0; s < 8; s++) begin
            start({mspx_pkg::OP_TEST_FLAG, 3'(s), mspx_pkg::ADRS_DIRECT}, 16'h0300);
            check(17'({d_we, d_tag, d_wd[16]}), 17'({2'b11, v_tf[s]}), "flag to tag");
            check(17'(d_addr), 17'h00300, "flag move address");
            finish();
            check(17'({f_tag, f_ov, f_sg, f_z, f_c}), 17'(e_flags), "flags kept");
        end
        $display("test flag_move done");
        for (int al = 0; al < 2; al++) begin
            v_ph = 16'hbeee + 16'(al);
            start({mspx_pkg::OP_STR_GRP, 2'd2, mspx_pkg::SUB_FROM_PH, 1'(al), 1'b0}, 16'h0000);
            finish();
            check(17'(al ? alt1[2] : acc1[2]), 17'(v_ph), "product high to second word");
            check(17'({f_z, f_c}), 17'(e_flags[1:0]), "carry zero kept");
        end
        $display("test from_product_high done");
        load(2'd3, 1'b0, 16'h1111, 16'h2222);
        start({mspx_pkg::OP_STR_GRP, 2'd3, mspx_pkg::SUB_ACC_ACC, 2'b10}, 16'h0000);
        finish();
        check(17'({alt0[3], 1'b0}), 17'({16'h1111, 1'b0}), "acc to alt word0");
        check(17'(alt1[3]), 17'h02222, "acc to alt word1");
        load(2'd3, 1'b1, 16'h3333, 16'h4444);
        start({mspx_pkg::OP_STR_GRP, 2'd3, mspx_pkg::SUB_ACC_ACC, 2'b01}, 16'h0000);
        finish();
        check(17'(acc0[3]), 17'h03333, "alt to acc word0");
        check(17'(acc1[3]), 17'h04444, "alt to acc word1");
        start({4'h1, 1'b0, 2'b11, 2'd3, mspx_pkg::ADRS_DIRECT}, 16'h0080);
        check(17'({d_we, d_wd[15:0]}), 17'h13333, "store word0");
        check(17'({d_wd2[15:0]}), 17'h04444, "store word1");
        check(17'(d_addr), 17'h00080, "store address");
        finish();
        $display("test accumulator_moves done");
        v_pm1 = 16'habcd;
        v_pm2 = 16'h1357;
        start({5'h0b, 2'b11, 2'd3, mspx_pkg::ADRS_DIRECT}, 16'h0200);
        check(17'(p_addr), 17'h03333, "lookup program address");
        check(17'({d_we, d_wd[15:0]}), 17'h1abcd, "lookup word0");
        check(17'(d_wd2[15:0]), 17'h01357, "lookup word1");
        check(17'(d_addr), 17'h00200, "lookup data address");
        finish();
        $display("test lookup done");
        final_report();
    end

    initial begin
        #(25 * 20000);
        n_errors++;
        $display("ERROR %0t run limit reached", $time);
        final_report();
    end
endmodule : test_move_sub_product_and_flag_exec
